// ### common/asc_flash_regs.svh
// Constants of the serial configuration flash port.
// Assumes inclusion by the package and the design file only.
`ifndef ASC_FLASH_REGS_SVH
`define ASC_FLASH_REGS_SVH

// Variant capacity in bits; one of 1048576, 4194304, 16777216,
// 67108864 or 134217728. Address logic is sized from it.
`define ASC_MEM_BITS 1048576
`define ASC_MEM_BYTES (`ASC_MEM_BITS / 8)
`define ASC_ADDR_W $clog2(`ASC_MEM_BYTES)

// Serial frame layout
`define ASC_CMD_W 8
`define ASC_LINK_ADDR_W 24
`define ASC_DUMMY_BITS 8
`define ASC_BYTE_W 8

// Instruction that starts a configuration read
`define ASC_READ_OP 8'h0b

// Value of an erased byte
`define ASC_ERASED_BYTE 8'hff

`endif

// ### common/asc_flash_pkg.sv
// Types shared by the serial configuration flash port.
// Assumes asc_flash_regs.svh is on the include path.
`include "asc_flash_regs.svh"

package asc_flash_pkg;

  typedef enum logic [2:0] {
    ASC_L_CMD = 3'b000,
    ASC_L_ADDR = 3'b001,
    ASC_L_DUMMY = 3'b011,
    ASC_L_DATA = 3'b010,
    ASC_L_IGNORE = 3'b110
  } asc_link_phase_t;

  typedef enum logic {
    ASC_S_ERASE = 1'b0,
    ASC_S_READY = 1'b1
  } asc_sys_phase_t;

  typedef struct packed {
    asc_link_phase_t phase;
    logic [4:0] cnt;
    logic [`ASC_CMD_W-1:0] sh_in;
    logic [`ASC_LINK_ADDR_W-1:0] addr;
    logic req;
    logic ack_s1;
    logic ack_s2;
    logic ack_seen;
    logic [`ASC_BYTE_W-1:0] buf_byte;
    logic [`ASC_BYTE_W-1:0] sh_out;
  } asc_link_t;

  typedef struct packed {
    asc_sys_phase_t phase;
    logic [`ASC_ADDR_W-1:0] ecnt;
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic ack;
    logic [`ASC_BYTE_W-1:0] rdata;
  } asc_sys_t;

  typedef struct packed {
    logic [`ASC_ADDR_W-1:0] addr;
    logic [`ASC_BYTE_W-1:0] data;
  } asc_prog_t;

endpackage : asc_flash_pkg

// ### rtl/asc_flash_port.sv
// Serial side of a configuration flash: the master clocks in an
// instruction and address and the memory streams bytes back.
// Assumes the master owns the serial clock and the select line, and
// that the serial clock only runs while the memory is selected.
// Contract
// [RQ1] The link is four signals: clock, select, instruction in, data out.
// [RQ2] The master makes the serial clock; the memory only follows it.
// [RQ3] The master drives select low before clocking in an instruction.
// [RQ4] Once selected, the master shifts in an instruction, then an address.
// [RQ5] On a read the memory launches each data bit on a falling edge.
// [RQ6] The master captures each bit on the following falling edge.
// [RQ7] A bad done line makes the master pulse its error line and restart.
// [RQ8] After a good load the master releases done, then initializes.
// [RQ9] The master holds its start input low until the memory is powered.
// [RQ10] Every unprogrammed location reads back as all ones. Only bytes below ERASE_LEN are swept erased.
// [RQ11] The memory does not cascade; one memory holds all the data.
// [RQ12] In a chain the first target reads the memory, the rest are slaves.
// [RQ13] Capacity is one of the listed variants; addressing fits it.
// [RQ14] With select high the clock is ignored, the output floats, and
// a partial instruction is dropped.

`timescale 1ns/1ps
`default_nettype none

`include "asc_flash_regs.svh"

module asc_flash_port import asc_flash_pkg::*; #(
  parameter int ERASE_LEN = `ASC_MEM_BYTES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic serial_clock_line_in,
  input wire logic memory_select_low_in,
  input wire logic serial_instruction_input_in,
  output logic master_data_input_out,
  output logic master_data_oe_n_out,
  input wire asc_prog_t prog_in,
  input wire logic prog_valid_in,
  output logic prog_ready_out,
  output logic erased_out
);

  localparam int MEM_BYTES = `ASC_MEM_BYTES;
  localparam int AW = `ASC_ADDR_W;
  localparam logic [AW-1:0] ERASE_LAST = AW'(ERASE_LEN - 1);

  // Link domain: clocked by the master's serial clock.
  asc_link_t link;
  asc_link_t next_link;
  logic dout;
  logic drive;

  // System domain
  asc_sys_t sys;
  asc_sys_t next_sys;
  logic [`ASC_BYTE_W-1:0] mem [MEM_BYTES];

  wire logic din = serial_instruction_input_in;
  wire logic [`ASC_CMD_W-1:0] cmd_word = {link.sh_in[6:0], din};
  wire logic byte_end = (link.cnt[2:0] == 3'h7);
  wire logic ack_new = (link.ack_s2 != link.ack_seen);

  always_comb begin
    next_link = link;
    next_link.ack_s1 = sys.ack;
    next_link.ack_s2 = link.ack_s1;
    // A prefetched byte lands in the buffer once its ack crosses
    if (ack_new) begin
      next_link.ack_seen = link.ack_s2;
      next_link.buf_byte = sys.rdata;
    end
    unique case (link.phase)
      ASC_L_CMD: begin
        next_link.sh_in = cmd_word;
        next_link.cnt = link.cnt + 5'h1;
        if (byte_end) begin
          next_link.cnt = 5'h0;
          if (cmd_word == `ASC_READ_OP) begin
            next_link.phase = ASC_L_ADDR;
          end else begin
            // Unknown opcodes are dropped until deselect
            next_link.phase = ASC_L_IGNORE;
          end
        end
      end
      ASC_L_ADDR: begin
        next_link.addr = {link.addr[`ASC_LINK_ADDR_W-2:0], din};
        next_link.cnt = link.cnt + 5'h1;
        if (link.cnt == 5'(`ASC_LINK_ADDR_W - 1)) begin
          // Address is complete on this edge; ask for the first byte
          next_link.cnt = 5'h0;
          next_link.phase = ASC_L_DUMMY;
          next_link.req = ~link.req;
        end
      end
      ASC_L_DUMMY: begin
        // Dummy bits give the fetch time to cross both domains
        next_link.cnt = link.cnt + 5'h1;
        if (link.cnt == 5'(`ASC_DUMMY_BITS - 1)) begin
          next_link.cnt = 5'h0;
          next_link.phase = ASC_L_DATA;
          next_link.sh_out = ack_new ? sys.rdata : link.buf_byte;
          next_link.addr = link.addr + 24'h1;
          next_link.req = ~link.req;
        end
      end
      ASC_L_DATA: begin
        next_link.sh_out = {link.sh_out[6:0], 1'b1};
        next_link.cnt = {2'h0, link.cnt[2:0] + 3'h1};
        if (byte_end) begin
          next_link.sh_out = ack_new ? sys.rdata : link.buf_byte;
          next_link.addr = link.addr + 24'h1;
          next_link.req = ~link.req;
        end
      end
      ASC_L_IGNORE: begin
        next_link.cnt = 5'h0;
      end
      default: begin
        next_link.phase = ASC_L_IGNORE;
      end
    endcase
  end

  // Select high acts as the link reset: the clock may be dead then, so
  // waiting for an edge would leave a half-shifted opcode behind.
  always_ff @(posedge serial_clock_line_in or
              posedge memory_select_low_in) begin
    if (memory_select_low_in) begin
      link.phase <= ASC_L_CMD; // see [RQ14]
      link.cnt <= 5'h0;
      link.sh_in <= 8'h00;
      link.addr <= 24'h000000;
      link.ack_s1 <= 1'b0;
      link.ack_s2 <= 1'b0;
      link.buf_byte <= `ASC_ERASED_BYTE;
      link.sh_out <= `ASC_ERASED_BYTE;
      // Toggles restart at zero so they are never unknown; a stale ack
      // only refills the buffer, and the real fetch overwrites it later
      link.req <= 1'b0;
      link.ack_seen <= 1'b0;
    end else begin
      link.phase <= next_link.phase;
      link.cnt <= next_link.cnt;
      link.sh_in <= next_link.sh_in;
      link.addr <= next_link.addr;
      link.ack_s1 <= next_link.ack_s1;
      link.ack_s2 <= next_link.ack_s2;
      link.buf_byte <= next_link.buf_byte;
      link.sh_out <= next_link.sh_out;
      link.req <= next_link.req;
      link.ack_seen <= next_link.ack_seen;
    end
  end

  // Output stage launches on the falling edge, a full bit ahead of the master's capture
  always_ff @(negedge serial_clock_line_in or
              posedge memory_select_low_in) begin
    if (memory_select_low_in) begin
      drive <= 1'b0; // see [RQ14]
      dout <= 1'b1;
    end else begin
      drive <= (link.phase == ASC_L_DATA); // see [RQ5]
      dout <= link.sh_out[7]; // see [RQ5]
    end
  end

  // Only one data pin exists; nothing is offered for cascading.
  assign master_data_input_out = dout; // see [RQ1] [RQ11]
  assign master_data_oe_n_out = memory_select_low_in | ~drive; // see [RQ14]

  // System domain: erase sweep, programming and byte fetches.
  wire logic req_new = (sys.req_s2 != sys.req_seen);
  wire logic [AW-1:0] fetch_addr = link.addr[AW-1:0]; // see [RQ13]

  always_comb begin
    next_sys = sys;
    next_sys.req_s1 = link.req;
    next_sys.req_s2 = sys.req_s1;
    unique case (sys.phase)
      ASC_S_ERASE: begin
        next_sys.ecnt = sys.ecnt + AW'(1);
        if (sys.ecnt == ERASE_LAST) begin
          next_sys.phase = ASC_S_READY;
        end
      end
      ASC_S_READY: begin
        next_sys.ecnt = sys.ecnt;
      end
    endcase
    if (req_new) begin
      next_sys.req_seen = sys.req_s2;
      next_sys.ack = ~sys.ack;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sys.phase <= ASC_S_ERASE;
      sys.ecnt <= '0;
      sys.req_s1 <= 1'b0;
      sys.req_s2 <= 1'b0;
      sys.req_seen <= 1'b0;
      sys.ack <= 1'b0;
      sys.rdata <= `ASC_ERASED_BYTE;
    end else begin
      sys <= next_sys;
      if (req_new) begin
        // Still erasing: the byte is all ones regardless of the array
        sys.rdata <= (sys.phase == ASC_S_ERASE) ?
                     `ASC_ERASED_BYTE : mem[fetch_addr]; // see [RQ10]
      end
    end
  end

  // Array holds no reset; the sweep after reset writes its first ERASE_LEN bytes erased.
  // Programming can only clear bits, as a flash cell would.
  always_ff @(posedge clk_in) begin
    if (sys.phase == ASC_S_ERASE) begin
      mem[sys.ecnt] <= `ASC_ERASED_BYTE; // see [RQ10]
    end else if (prog_valid_in) begin
      mem[prog_in.addr] <= mem[prog_in.addr] & prog_in.data;
    end
  end

  assign prog_ready_out = (sys.phase == ASC_S_READY);
  assign erased_out = (sys.phase == ASC_S_READY);

  // Checks on the link domain
  sequence data_bit_s;
    link.phase == ASC_L_DATA && !memory_select_low_in;
  endsequence

  sequence addr_done_s;
    link.phase == ASC_L_ADDR && link.cnt == 5'(`ASC_LINK_ADDR_W - 1);
  endsequence

  property falling_launch_p;
    @(posedge serial_clock_line_in) disable iff (memory_select_low_in)
      data_bit_s ##1 data_bit_s |-> master_data_input_out == link.sh_out[7];
  endproperty

  link_bit_launch_a: assert property (falling_launch_p) // see [RQ5]
    else $error("data bit not launched from the shift register");

  data_drive_a: assert property ( // see [RQ5]
    @(posedge serial_clock_line_in) disable iff (memory_select_low_in)
      data_bit_s ##1 data_bit_s |-> !master_data_oe_n_out)
    else $error("data pin not driven during a read");

  dummy_then_data_a: assert property ( // see [RQ5]
    @(posedge serial_clock_line_in) disable iff (memory_select_low_in)
      addr_done_s |=> link.phase == ASC_L_DUMMY [*8] ##1
      link.phase == ASC_L_DATA)
    else $error("read did not reach data after eight dummy bits");

  // Checks on the system domain
  idle_float_a: assert property ( // see [RQ14]
    @(posedge clk_in) disable iff (rst_in)
      memory_select_low_in |-> master_data_oe_n_out &&
      link.phase == ASC_L_CMD && link.cnt == 5'h0)
    else $error("deselected memory still drives or decodes");

  erased_fetch_a: assert property ( // see [RQ10]
    @(posedge clk_in) disable iff (rst_in)
      req_new && sys.phase == ASC_S_ERASE |=>
      sys.rdata == `ASC_ERASED_BYTE)
    else $error("fetch during erase did not return all ones");

  erase_end_a: assert property ( // see [RQ10]
    @(posedge clk_in) disable iff (rst_in)
      sys.phase == ASC_S_ERASE && sys.ecnt == ERASE_LAST |=>
      sys.phase == ASC_S_READY && erased_out)
    else $error("erase sweep did not finish at the last byte");

  fetch_answer_a: assert property ( // see [RQ13]
    @(posedge clk_in) disable iff (rst_in)
      req_new && sys.phase == ASC_S_READY |=>
      sys.rdata == mem[$past(fetch_addr)] && sys.ack != $past(sys.ack))
    else $error("fetch did not answer from the addressed byte");

  // Sequences for the instruction decode checks
  sequence read_op_s;
    link.phase == ASC_L_CMD && byte_end && cmd_word == `ASC_READ_OP;
  endsequence

  sequence other_op_s;
    link.phase == ASC_L_CMD && byte_end && cmd_word != `ASC_READ_OP;
  endsequence

  read_decode_a: assert property ( // see [RQ5]
    @(posedge serial_clock_line_in) disable iff (memory_select_low_in)
      read_op_s |=> link.phase == ASC_L_ADDR && link.cnt == 5'h0)
    else $error("read opcode did not start the address phase");

  other_ignored_a: assert property ( // see [RQ14]
    @(posedge serial_clock_line_in) disable iff (memory_select_low_in)
      other_op_s |=> link.phase == ASC_L_IGNORE [*2])
    else $error("unknown opcode was not ignored");

  header_quiet_a: assert property ( // see [RQ14]
    @(posedge serial_clock_line_in) disable iff (memory_select_low_in)
      link.phase != ASC_L_DATA |-> master_data_oe_n_out)
    else $error("data pin driven outside the data phase");

  sweep_hold_a: assert property ( // see [RQ10]
    @(posedge clk_in) disable iff (rst_in)
      sys.phase == ASC_S_READY |=> sys.phase == ASC_S_READY &&
      prog_ready_out)
    else $error("erase sweep restarted without a reset");

endmodule : asc_flash_port

`default_nettype wire

// ### verif/asc_master_model.sv
// Behavioural configuration master for the serial flash port.
// Assumes one caller at a time; clock and select idle between frames.
`timescale 1ns/1ps
`default_nettype none
module asc_master_model (
  output logic serial_clock_line_out,
  output logic memory_select_low_out,
  output logic serial_instruction_input_out,
  input wire logic master_data_input_in,
  input wire logic master_data_oe_n_in
);
  initial begin
    serial_clock_line_out = 1'b0;
    serial_instruction_input_out = 1'b0;
    // One select pulse clears the link logic, which has no other reset
    memory_select_low_out = 1'b0;
    #1 memory_select_low_out = 1'b1;
  end

  // Clock only runs inside a frame; a short header aborts the frame
  task automatic frame(input logic [39:0] hdr, input int nhdr,
                       input int nb, output logic [31:0] got,
                       output int lowcnt);
    got = '0;
    lowcnt = 0;
    #7;
    memory_select_low_out = 1'b0;
    #15;
    for (int i = 0; i < nhdr; i++) begin
      serial_instruction_input_out = hdr[39-i];
      #15 serial_clock_line_out = 1'b1;
      #15 serial_clock_line_out = 1'b0;
    end
    for (int i = 0; i < nb * 8; i++) begin
      #15 serial_clock_line_out = 1'b1;
      #15 got = {got[30:0], master_data_input_in};
      if (master_data_oe_n_in === 1'b0) lowcnt++;
      serial_clock_line_out = 1'b0;
    end
    #15 memory_select_low_out = 1'b1;
    // Released line must not keep showing the last bit
    serial_instruction_input_out = ~serial_instruction_input_out;
  endtask : frame
endmodule : asc_master_model
`default_nettype wire

// ### verif/tb_active_serial_config_flash_port.sv
// Self-checking bench for the serial configuration flash port.
// Assumes the master model owns the link and the bench the program port.
`timescale 1ns/1ps
`default_nettype none
module tb_active_serial_config_flash_port import asc_flash_pkg::*;;
  // Short erase sweep keeps the run small; only bytes 0..63 are erased
  localparam int ERASE_LEN = 64;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic sclk, sel_n, sdi, dout, oe_n, prog_ready_out, erased_out;
  logic prog_valid_in = 1'b0;
  asc_prog_t prog_in = '0;
  wire data_pin;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  // Released pin shows the inverse so a missing drive is caught
  assign data_pin = oe_n ? ~dout : dout;
  always #5 clk_in = ~clk_in;

  asc_flash_port #(.ERASE_LEN(ERASE_LEN)) DUT (
    .clk_in(clk_in), .rst_in(rst_in), .serial_clock_line_in(sclk),
    .memory_select_low_in(sel_n), .serial_instruction_input_in(sdi),
    .master_data_input_out(dout), .master_data_oe_n_out(oe_n),
    .prog_in(prog_in), .prog_valid_in(prog_valid_in),
    .prog_ready_out(prog_ready_out), .erased_out(erased_out));

  asc_master_model master (
    .serial_clock_line_out(sclk), .memory_select_low_out(sel_n),
    .serial_instruction_input_out(sdi), .master_data_input_in(data_pin),
    .master_data_oe_n_in(oe_n));

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask : check

  task automatic prog2(input asc_prog_t a, input asc_prog_t b);
    @(negedge clk_in);
    prog_in = a;
    prog_valid_in = 1'b1;
    @(negedge clk_in);
    prog_in = b;
    @(negedge clk_in);
    prog_valid_in = 1'b0;
  endtask : prog2

  task automatic rd(input logic [7:0] op, input logic [23:0] a,
                    input int nb, input logic [31:0] exp, input int low);
    logic [31:0] got;
    int seen;
    master.frame({op, a, 8'h00}, 40, nb, got, seen);
    #1;
    if (low > 0) check(got, exp);
    check(32'(seen), 32'(low));
    check({31'h0, oe_n}, 32'h1);
  endtask : rd

  task automatic t_reset_erase();
    repeat (8) @(negedge clk_in);
    check({30'h0, prog_ready_out, erased_out}, 32'h0);
    check({31'h0, oe_n}, 32'h1);
    rst_in = 1'b0;
    // The sweep has passed bytes 0 and 1 when these writes arrive, so a
    // write that got through would show up in the read below
    prog2('{addr: 17'h0, data: 8'h00}, '{addr: 17'h1, data: 8'h00});
    for (int i = 0; i < ERASE_LEN + 20 && prog_ready_out !== 1'b1; i++)
      @(negedge clk_in);
    check({30'h0, prog_ready_out, erased_out}, 32'h3);
    rd(8'h0b, 24'h0, 4, 32'hffffffff, 32);
    rd(8'h0b, 24'h3b, 4, 32'hffffffff, 32);
  endtask : t_reset_erase

  task automatic t_prog_read();
    prog2('{addr: 17'ha, data: 8'h5a}, '{addr: 17'hb, data: 8'ha5});
    rd(8'h0b, 24'ha, 2, 32'h5aa5, 16);
    // Programming only clears bits
    prog2('{addr: 17'ha, data: 8'h0f}, '{addr: 17'hb, data: 8'hf0});
    rd(8'h0b, 24'h9, 3, 32'hff0aa0, 24);
  endtask : t_prog_read

  task automatic t_refused_abort();
    logic [31:0] got;
    int seen;
    rd(8'h03, 24'ha, 1, 32'h0, 0);
    master.frame({8'h0b, 32'h0}, 5, 0, got, seen);
    #1;
    check({31'h0, oe_n}, 32'h1);
    rd(8'h0b, 24'hb, 1, 32'ha0, 8);
  endtask : t_refused_abort

  // Reset lands mid-frame so the first fetch meets the erase sweep
  task automatic t_mid_reset();
    @(negedge clk_in);
    fork
      rd(8'h0b, 24'ha, 1, 32'hff, 8);
      begin
        repeat (40) @(negedge clk_in);
        rst_in = 1'b1;
        repeat (8) @(negedge clk_in);
        check({30'h0, prog_ready_out, erased_out}, 32'h0);
        rst_in = 1'b0;
      end
    join
  endtask : t_mid_reset

  initial begin
    t_reset_erase();
    t_prog_read();
    t_refused_abort();
    t_mid_reset();
    give_verdict();
  end
endmodule : tb_active_serial_config_flash_port
`default_nettype wire
